// *** design/rag_addr_gen.v ***
// RAM and ROM address generation with its own fetch sequencer.
// Assumes ROM and RAM arrays answer combinationally to the held address on
// core_clk, and that pointer, accumulator and auxiliary values come from
// core logic on the same clock.
`timescale 1ns/1ns
`include "rag_consts.vh"

module rag_addr_gen (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst,
  // Program ROM
  output reg  [13:0] rom_addr,
  input  wire [9:0]  rom_data,
  // Data RAM
  output reg  [9:0]  ram_addr,
  output reg         ram_rd,
  output reg         ram_wr,
  output reg  [3:0]  ram_wdata,
  input  wire [3:0]  ram_rdata,
  // Pointer registers held by the core
  input  wire [1:0]  ptr_bank,
  input  wire [3:0]  ptr_hi,
  input  wire [3:0]  ptr_lo,
  // Accumulator and auxiliary register
  input  wire [3:0]  acc_val,
  input  wire [3:0]  aux_val,
  output reg         acc_load,
  output reg  [3:0]  acc_load_data,
  output reg         aux_load,
  output reg  [3:0]  aux_load_data,
  // Port output latches
  output reg  [3:0]  out_latch_one,
  output reg  [3:0]  out_latch_two,
  // Hand-off to the rest of the core
  output reg         instr_valid,
  output reg  [9:0]  instr_word,
  output reg         call_push,
  output reg  [13:0] call_ret_addr,
  output reg  [13:0] instr_counter
);

  // --------------------------------------------------------------------
  // Sequencer states, one-hot
  // --------------------------------------------------------------------
  localparam [4:0] S_FETCH  = 5'h01;  // Present the counter to the ROM.
  localparam [4:0] S_DECODE = 5'h02;  // First word is on rom_data.
  localparam [4:0] S_WORD2  = 5'h04;  // Second word is on rom_data.
  localparam [4:0] S_TABLE  = 5'h08;  // Table word is on rom_data.
  localparam [4:0] S_RAM    = 5'h10;  // RAM read data is on ram_rdata.

  reg  [4:0]  state;                  // Current sequencer state.
  reg  [9:0]  op_word;                // First word kept for two-step ops.
  wire [13:0] target;                 // Formed branch or table address.
  wire [9:0]  target_w1;              // Word that carries the immediate.
  wire [1:0]  target_kind;            // Kind of target to form.

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  // Maps an opcode to the kind of target it needs; used for the first
  // word while decoding and for the kept word while the second arrives.
  function [1:0] kind_of;
    input [9:0] word;
    begin
      casez (word)
        `RAG_OP_PAGE_JUMP: kind_of = `RAG_TK_PAGE;
        `RAG_OP_ZERO_CALL: kind_of = `RAG_TK_ZERO;
        `RAG_OP_LONG:      kind_of = `RAG_TK_LONG;
        default:           kind_of = `RAG_TK_TABLE;
      endcase
    end
  endfunction

  // True when the long-form word is the subroutine invoke variant.
  function is_invoke;
    input [9:0] word;
    begin
      is_invoke = (word[`RAG_LONG_SUB_HI:`RAG_LONG_SUB_LO] == `RAG_SUB_INVOKE);
    end
  endfunction

  // Memory-register window address: fixed base plus the digit number.
  function [9:0] mreg_addr;
    input [9:0] word;
    begin
      mreg_addr = `RAG_MREG_BASE + {6'h00, word[3:0]};
    end
  endfunction

  // --------------------------------------------------------------------
  // Target former
  // --------------------------------------------------------------------
  // While the second word is on the bus the kept first word drives the
  // immediate; otherwise the word being decoded does.
  assign target_w1   = (state == S_WORD2) ? op_word : rom_data;
  assign target_kind = kind_of(target_w1);

  rag_target u_target (
    .kind      (target_kind),
    .cur_count (instr_counter),
    .word_one  (target_w1),
    .word_two  (rom_data),
    .acc_val   (acc_val),
    .aux_val   (aux_val),
    .target    (target)
  );

  // --------------------------------------------------------------------
  // Sequencer and datapath registers
  // --------------------------------------------------------------------
  // Every pulse output defaults low each cycle and is raised for exactly
  // one cycle by the branch that needs it.
  always @(posedge core_clk) begin
    if (rst) begin
      state         <= S_FETCH;
      op_word       <= 10'h000;
      rom_addr      <= 14'h0000;
      ram_addr      <= 10'h000;
      ram_rd        <= 1'b0;
      ram_wr        <= 1'b0;
      ram_wdata     <= 4'h0;
      acc_load      <= 1'b0;
      acc_load_data <= 4'h0;
      aux_load      <= 1'b0;
      aux_load_data <= 4'h0;
      out_latch_one <= 4'h0;
      out_latch_two <= 4'h0;
      instr_valid   <= 1'b0;
      instr_word    <= 10'h000;
      call_push     <= 1'b0;
      call_ret_addr <= 14'h0000;
      instr_counter <= `RAG_PC_RESET;
    end else begin
      ram_rd      <= 1'b0;
      ram_wr      <= 1'b0;
      acc_load    <= 1'b0;
      aux_load    <= 1'b0;
      instr_valid <= 1'b0;
      call_push   <= 1'b0;
      case (state)
        S_FETCH: begin
          // Fetch the opcode word and step past it.
          rom_addr      <= instr_counter;
          instr_counter <= instr_counter + 14'h0001;
          state         <= S_DECODE;
        end
        S_DECODE: begin
          op_word <= rom_data;
          state   <= S_FETCH;
          casez (rom_data)
            `RAG_OP_PAGE_JUMP: begin
              instr_counter <= target;
            end
            `RAG_OP_ZERO_CALL: begin
              // Return point is the already advanced counter.
              call_push     <= 1'b1;
              call_ret_addr <= instr_counter;
              instr_counter <= target;
            end
            `RAG_OP_TABLE_JUMP: begin
              instr_counter <= target;
            end
            `RAG_OP_TABLE_LOAD: begin
              // Read the table word; the counter is left where it is.
              rom_addr <= target;
              state    <= S_TABLE;
            end
            `RAG_OP_LONG, `RAG_OP_DIR_LOAD, `RAG_OP_DIR_STORE: begin
              // Two-word forms: the second word is fetched and counted too.
              rom_addr      <= instr_counter;
              instr_counter <= instr_counter + 14'h0001;
              state         <= S_WORD2;
            end
            `RAG_OP_IND_LOAD, `RAG_OP_IND_STORE: begin
              ram_addr <= {ptr_bank, ptr_hi, ptr_lo};
              if (rom_data[`RAG_STORE_BIT]) begin
                ram_wr    <= 1'b1;
                ram_wdata <= acc_val;
              end else begin
                ram_rd <= 1'b1;
                state  <= S_RAM;
              end
            end
            `RAG_OP_MREG_LOAD, `RAG_OP_MREG_SWAP: begin
              // Only these two opcodes ever form a window address.
              ram_addr <= mreg_addr(rom_data);
              ram_rd   <= 1'b1;
              state    <= S_RAM;
            end
            default: begin
              // Not an addressing instruction: hand it to the core.
              instr_valid <= 1'b1;
              instr_word  <= rom_data;
            end
          endcase
        end
        S_WORD2: begin
          state <= S_FETCH;
          casez (op_word)
            `RAG_OP_LONG: begin
              if (is_invoke(op_word)) begin
                call_push     <= 1'b1;
                call_ret_addr <= instr_counter;
              end
              instr_counter <= target;
            end
            default: begin
              // Direct form: the whole second word is the RAM address.
              ram_addr <= rom_data;
              if (op_word[`RAG_STORE_BIT]) begin
                ram_wr    <= 1'b1;
                ram_wdata <= acc_val;
              end else begin
                ram_rd <= 1'b1;
                state  <= S_RAM;
              end
            end
          endcase
        end
        S_TABLE: begin
          // Bits 9 and 8 steer, bits 7 to 0 carry the data; both writes
          // may happen in the same cycle.
          if (rom_data[`RAG_TBL_ACC_BIT]) begin
            acc_load      <= 1'b1;
            acc_load_data <= rom_data[3:0];
            aux_load      <= 1'b1;
            aux_load_data <= rom_data[7:4];
          end
          if (rom_data[`RAG_TBL_LATCH_BIT]) begin
            out_latch_one <= rom_data[3:0];
            out_latch_two <= rom_data[7:4];
          end
          state <= S_FETCH;
        end
        S_RAM: begin
          // Read data lands in the accumulator; a swap writes the old
          // accumulator back to the same address in the same step.
          acc_load      <= 1'b1;
          acc_load_data <= ram_rdata;
          casez (op_word)
            `RAG_OP_MREG_SWAP: begin
              ram_wr    <= 1'b1;
              ram_wdata <= acc_val;
            end
            default: begin
              ram_wr <= 1'b0;
            end
          endcase
          state <= S_FETCH;
        end
        default: begin
          // Unreachable code; recover cleanly.
          state <= S_FETCH;
        end
      endcase
    end
  end

endmodule

// *** design/rag_consts.vh ***
// Constants for the RAM and ROM address generation block of the 4-bit core.
// Assumes inclusion by bare name from design files compiled on core_clk.
//
// What this block does
// - Indirect RAM address is bank, high, low pointers.
// - Direct RAM access uses whole second word.
// - Window base-plus-digit address formed by only two instructions.
// - Long transfers replace all fourteen counter bits.
// - Page jump replaces counter bits seven to zero.
// - Page jump at page end lands next page.
// - Zero-page invoke loads six bits, clears rest.
// - Table jump target from immediate, accumulator, auxiliary.
// - Table word bit eight loads accumulator pair.
// - Table word bit nine loads both output latches.
// - Both bits set performs both writes together.
// - Table load leaves the instruction counter flow alone.
// - Ten-bit program words, two flags above data.
`ifndef RAG_CONSTS_VH
`define RAG_CONSTS_VH

// ----------------------------------------------------------------------
// Instruction encodings (casez patterns on a 10-bit program word)
// ----------------------------------------------------------------------
`define RAG_OP_PAGE_JUMP  10'b10????????
`define RAG_OP_ZERO_CALL  10'b0100??????
`define RAG_OP_TABLE_JUMP 10'b010100????
`define RAG_OP_TABLE_LOAD 10'b010101????
`define RAG_OP_LONG       10'b0110??????
`define RAG_OP_DIR_LOAD   10'b0111000000
`define RAG_OP_DIR_STORE  10'b0111000001
`define RAG_OP_IND_LOAD   10'b0111010000
`define RAG_OP_IND_STORE  10'b0111010001
`define RAG_OP_MREG_LOAD  10'b011110????
`define RAG_OP_MREG_SWAP  10'b011111????

// ----------------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------------
`define RAG_LONG_SUB_HI    5
`define RAG_LONG_SUB_LO    4
`define RAG_SUB_INVOKE     2'h2
`define RAG_TBL_ACC_BIT    8
`define RAG_TBL_LATCH_BIT  9
`define RAG_SWAP_BIT       4
`define RAG_STORE_BIT      0
`define RAG_MREG_BASE      10'h020
`define RAG_PC_RESET       14'h0000

// ----------------------------------------------------------------------
// Target kinds handed to the target former
// ----------------------------------------------------------------------
`define RAG_TK_LONG  2'h0
`define RAG_TK_PAGE  2'h1
`define RAG_TK_ZERO  2'h2
`define RAG_TK_TABLE 2'h3

`endif

// *** design/rag_target.v ***
// Branch target former for the address generation block.
// Assumes the caller selects the kind and supplies the already advanced counter.
`timescale 1ns/1ns
`include "rag_consts.vh"

module rag_target (
  // Selection and operands
  input  wire [1:0]  kind,
  input  wire [13:0] cur_count,
  input  wire [9:0]  word_one,
  input  wire [9:0]  word_two,
  input  wire [3:0]  acc_val,
  input  wire [3:0]  aux_val,
  // Result
  output reg  [13:0] target
);

  // --------------------------------------------------------------------
  // Target selection
  // --------------------------------------------------------------------
  // Purely combinational; the caller registers the result into the counter, or into rom_addr for a table load.
  always @* begin
    case (kind)
      `RAG_TK_LONG: begin
        target = {word_one[3:0], word_two};
      end
      `RAG_TK_PAGE: begin
        // Upper bits come from the counter after its increment, so a jump
        // sitting at the last word of a page reaches into the next page.
        target = {cur_count[13:8], word_one[7:0]};
      end
      `RAG_TK_ZERO: begin
        target = {8'h00, word_one[5:0]};
      end
      default: begin
        target = {2'h0, word_one[3:0], acc_val, aux_val};
      end
    endcase
  end

endmodule

// *** testbench/rag_addr_gen_props.sv ***
// Port checker for the address generation block.
// Assumes rom_data is the word at rom_addr within the same cycle.
`timescale 1ns/1ns
module rag_addr_gen_props (
  // Clock and reset
  input wire        core_clk,
  input wire        rst,
  // Memory side
  input wire [13:0] rom_addr,
  input wire [9:0]  rom_data,
  input wire [9:0]  ram_addr,
  input wire        ram_rd,
  // Core side
  input wire [1:0]  ptr_bank,
  input wire [3:0]  ptr_hi,
  input wire [3:0]  ptr_lo,
  input wire [3:0]  acc_val,
  input wire [3:0]  aux_val,
  input wire        acc_load,
  input wire [3:0]  acc_load_data,
  input wire        aux_load,
  input wire [3:0]  aux_load_data,
  input wire [3:0]  out_latch_one,
  input wire [3:0]  out_latch_two,
  input wire        call_push,
  input wire [13:0] call_ret_addr,
  input wire [13:0] instr_counter
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire [9:0] ptr = {ptr_bank, ptr_hi, ptr_lo};          // Indirect RAM address.
  wire [7:0] lat = {out_latch_two, out_latch_one};      // Both port latches.
  wire       tbl = acc_load && aux_load;                // Only a table load moves both.
  wire [13:0] nxt = rom_addr + 14'h1;                   // Plain advance past the fetch.
  a_ind_addr: assert property (ram_rd && $past(rom_data) == 10'h1D0 |->
    ram_addr == $past(ptr)) else $error("indirect address wrong");
  a_dir_addr: assert property (ram_rd && $past(rom_data, 2) == 10'h1C0 |->
    ram_addr == $past(rom_data)) else $error("direct address wrong");
  a_mreg_addr: assert property (ram_rd && $past(rom_data[9:5]) == 5'h0F |->
    ram_addr == 10'h020 + {6'h00, $past(rom_data[3:0])}) else $error("window address wrong");
  a_long_call: assert property (call_push && $past(rom_data[9:6], 2) == 4'h6 |->
    instr_counter == {$past(rom_data[3:0], 2), $past(rom_data)}) else $error("long target");
  a_page_jump: assert property ($past(rom_data[9:8]) == 2'h2 && $changed(instr_counter)
    && instr_counter != nxt |-> instr_counter == {$past(instr_counter[13:8]),
    $past(rom_data[7:0])}) else $error("page target wrong");
  a_zero_call: assert property (call_push && $past(rom_data[9:6]) == 4'h4 |->
    instr_counter == {8'h00, $past(rom_data[5:0])}) else $error("zero page target");
  a_table_jump: assert property ($past(rom_data[9:4]) == 6'h14 && $changed(instr_counter)
    && instr_counter != nxt |-> instr_counter == {2'h0, $past(rom_data[3:0]),
    $past(acc_val), $past(aux_val)}) else $error("table target wrong");
  a_table_acc: assert property (tbl |-> $past(rom_data[8]) &&
    {aux_load_data, acc_load_data} == $past(rom_data[7:0])) else $error("table acc load");
  a_latch_write: assert property ($changed(lat) |-> $past(rom_data[9]) &&
    lat == $past(rom_data[7:0])) else $error("latch write wrong");
  a_both_writes: assert property (tbl && $past(rom_data[9]) |->
    lat == $past(rom_data[7:0])) else $error("both writes apart");
  a_table_flow: assert property (tbl |=> rom_addr == $past(instr_counter))
    else $error("table load moved flow");
  a_call_ret: assert property (call_push |-> call_ret_addr == nxt)
    else $error("return address wrong");
  c_table: cover property (tbl);
  c_call: cover property (call_push);
  c_read: cover property (ram_rd);
endmodule
bind rag_addr_gen rag_addr_gen_props chk (.core_clk, .rst, .rom_addr, .rom_data, .ram_addr,
  .ram_rd, .ptr_bank, .ptr_hi, .ptr_lo, .acc_val, .aux_val, .acc_load, .acc_load_data,
  .aux_load, .aux_load_data, .out_latch_one, .out_latch_two, .call_push, .call_ret_addr,
  .instr_counter);

// *** testbench/rag_mem_model.sv ***
// Program ROM and data RAM arrays that face the address generation block.
// Assumes the bench loads the ROM; reads answer combinationally.
`timescale 1ns/1ns
module rag_mem_model (
  // Clock
  input  wire        core_clk,
  // Program ROM
  input  wire [13:0] rom_addr,
  output wire [9:0]  rom_data,
  // Data RAM
  input  wire [9:0]  ram_addr,
  input  wire        ram_wr,
  input  wire [3:0]  ram_wdata,
  output wire [3:0]  ram_rdata
);
  reg [9:0] rom [0:16383]; // Filled by the bench.
  reg [3:0] ram [0:1023];  // Digit store.
  integer   i;
  // Each digit starts unlike the data the bench writes, so stale reads show.
  initial for (i = 0; i < 1024; i = i + 1) ram[i] = i[3:0];
  assign rom_data  = rom[rom_addr];
  assign ram_rdata = ram[ram_addr];
  // A write lands on the edge that ends the write cycle.
  always @(posedge core_clk) if (ram_wr) ram[ram_addr] <= ram_wdata;
endmodule

// *** testbench/test_rag_addr_gen.sv ***
// Self-checking bench: runs one program four times with random operands.
// Assumes the memory model answers combinationally; events are queued in order.
`timescale 1ns/1ns
module test_rag_addr_gen;
  reg         core_clk = 1'b0;
  reg         rst      = 1'b1;
  reg  [1:0]  ptr_bank = 2'h0;
  reg  [3:0]  ptr_hi = 4'h0, ptr_lo = 4'h0, acc_val = 4'h0, aux_val = 4'h0;
  wire [13:0] rom_addr, call_ret_addr, instr_counter;
  wire [9:0]  rom_data, ram_addr, instr_word;
  wire [3:0]  ram_wdata, ram_rdata, acc_load_data, aux_load_data, out_latch_one, out_latch_two;
  wire        ram_rd, ram_wr, acc_load, aux_load, instr_valid, call_push;
  wire [7:0]  lat_now = {out_latch_two, out_latch_one}; // Both port latches.
  reg  [19:0] exq [$];        // Expected events, oldest first.
  reg  [23:0] prog [0:21] = '{24'h000001, 24'h0005D1, 24'h0009D0, 24'h000DC1, 24'h0013A5,
    24'h0015C0, 24'h001BA5, 24'h001DF5, 24'h0021E5, 24'h002553, 24'h00280A, 24'h002D30,
    24'h00C030, 24'h00C588, 24'h00C800, 24'h8000FF, 24'h8005A0, 24'h8008FE, 24'h03F8FE,
    24'h03FE10, 24'h044011, 24'h044542}; // Address above word.
  reg  [31:0] seed = 32'h61DF714A;
  reg  [9:0]  p;
  reg  [7:0]  d, last_lat = 8'h00;
  reg  [3:0]  m25 = 4'h5;     // Shadow of window digit five; it survives reset.
  reg         live = 1'b0;
  integer     miscompares = 0, total_checks = 0, cycles = 0, k, r;

  rag_addr_gen uut (
    .core_clk      (core_clk),
    .rst           (rst),
    .rom_addr      (rom_addr),
    .rom_data      (rom_data),
    .ram_addr      (ram_addr),
    .ram_rd        (ram_rd),
    .ram_wr        (ram_wr),
    .ram_wdata     (ram_wdata),
    .ram_rdata     (ram_rdata),
    .ptr_bank      (ptr_bank),
    .ptr_hi        (ptr_hi),
    .ptr_lo        (ptr_lo),
    .acc_val       (acc_val),
    .aux_val       (aux_val),
    .acc_load      (acc_load),
    .acc_load_data (acc_load_data),
    .aux_load      (aux_load),
    .aux_load_data (aux_load_data),
    .out_latch_one (out_latch_one),
    .out_latch_two (out_latch_two),
    .instr_valid   (instr_valid),
    .instr_word    (instr_word),
    .call_push     (call_push),
    .call_ret_addr (call_ret_addr),
    .instr_counter (instr_counter)
  );

  rag_mem_model mem (
    .core_clk  (core_clk),
    .rom_addr  (rom_addr),
    .rom_data  (rom_data),
    .ram_addr  (ram_addr),
    .ram_wr    (ram_wr),
    .ram_wdata (ram_wdata),
    .ram_rdata (ram_rdata)
  );

  always #5 core_clk = ~core_clk;

  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task give_verdict;
    begin
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask

  task note(input [3:0] kd, input [15:0] v);
    exq.push_back({kd, v});
  endtask

  // An event with nothing queued is itself a mismatch.
  task check_event(input [19:0] got);
    reg [19:0] want;
    begin
      want = (exq.size() != 0) ? exq.pop_front() : 20'hFFFFF;
      total_checks = total_checks + 1;
      if (got !== want) begin
        miscompares = miscompares + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, want);
      end
    end
  endtask

  // One compare task for each kind of result; the kind sits in bits 19 to 16
  // of the packed event, so every kind shares one ordered queue.
  task check_instr(input [9:0] w);
    check_event({10'h000, w});
  endtask

  // Accumulator load; the auxiliary nibble only counts when it is loaded too.
  task check_acc(input ld_aux, input [3:0] hi, input [3:0] lo);
    check_event({11'h080, ld_aux, ld_aux ? hi : 4'h0, lo});
  endtask

  task check_write(input [9:0] a, input [3:0] v);
    check_event({6'h08, a, v});
  endtask

  task check_call(input [13:0] ret);
    check_event({6'h0C, ret});
  endtask

  task check_latch(input [7:0] v);
    check_event({12'h400, v});
  endtask

  // Hang guard: the four runs need a few hundred cycles.
  always @(posedge core_clk) begin
    cycles = cycles + 1;
    if (cycles == 2000) begin
      miscompares = miscompares + 1;
      give_verdict;
    end
  end

  // Monitor: sample settled outputs just after each edge.
  always @(posedge core_clk) begin
    #1;
    if (live) begin
      if (instr_valid) check_instr(instr_word);
      if (acc_load) check_acc(aux_load, aux_load_data, acc_load_data);
      if (ram_wr) check_write(ram_addr, ram_wdata);
      if (call_push) check_call(call_ret_addr);
      if (lat_now !== last_lat) check_latch(lat_now);
    end
    last_lat = lat_now;
  end

  initial begin
    for (k = 0; k < 16384; k = k + 1) mem.rom[k] = (k[13:8] == 6'h02) ? {2'h0, k[7:0]} : 10'h3C3;
    for (k = 0; k < 22; k = k + 1) mem.rom[prog[k][23:10]] = prog[k][9:0];
    for (r = 0; r < 4; r = r + 1) begin
      seed = lfsr(seed);
      {ptr_bank, ptr_hi, ptr_lo, acc_val, aux_val} = seed[17:0];
      p = seed[17:8];
      d = seed[31:24];
      mem.rom[{6'h03, acc_val, aux_val}] = {r[1:0], d};
      rst = 1'b1;
      note(0, 16'h0001);
      note(2, {2'h0, p, acc_val});
      note(1, {12'h000, acc_val});
      note(2, {12'h3A5, acc_val});
      note(1, {12'h000, acc_val});
      note(1, {12'h000, (p == 10'h025) ? acc_val : m25});
      note(2, {12'h025, acc_val});
      note(1, {12'h000, acc_val});
      if (r[0]) note(1, {8'h01, d});
      if (r[1] && d != 8'h00) note(4, {8'h00, d});
      note(0, 16'h000A);
      note(3, 16'h000C);
      note(0, 16'h0030);
      note(0, 16'h00FF);
      note(3, 16'h2003);
      note(0, 16'h00FE);
      note(0, 16'h0011);
      note(0, {8'h00, acc_val, aux_val});
      m25 = acc_val;
      repeat (20) @(posedge core_clk);
      #1 rst = 1'b0;
      live = 1'b1;
      while (exq.size() != 0) @(posedge core_clk);
      live = 1'b0;
      #1;
    end
    give_verdict;
  end
endmodule
